// *** include/tdr_pkg.sv ***
// Purpose: Shared constants and types for the two-pin debug register block
// Assumes: Byte-wide debug registers, one system clock, one link clock
// Notes:   Link framing and command codes are defined here for both domains
package tdr_pkg;

  // Register data width
  localparam int TDR_DW = 8;

  // Target select codes
  localparam logic [7:0] TDR_TGT_PART_ID  = 8'h00;
  localparam logic [7:0] TDR_TGT_REV_ID   = 8'h01;
  localparam logic [7:0] TDR_TGT_DEV_CTL  = 8'h02;
  localparam logic [7:0] TDR_TGT_PROG_CTL = 8'hDF;
  localparam logic [7:0] TDR_TGT_EP_DATA  = 8'hBF;
  localparam logic [7:0] TDR_TGT_EP_STAT  = 8'hB7;
  localparam logic [7:0] TDR_TGT_ADDR_HI  = 8'hAF;
  localparam logic [7:0] TDR_TGT_ADDR_LO  = 8'hAE;
  localparam logic [7:0] TDR_TGT_CHECK_0  = 8'hA9;
  localparam logic [7:0] TDR_TGT_CHECK_1  = 8'hAA;
  localparam logic [7:0] TDR_TGT_CHECK_2  = 8'hAB;
  localparam logic [7:0] TDR_TGT_CHECK_3  = 8'hAC;

  // Reset value and answer for unmapped targets
  localparam logic [7:0] TDR_RST_BYTE = 8'h00;
  localparam logic [7:0] TDR_NO_BYTE  = 8'h00;

  // Status field positions
  localparam int TDR_BUSY_BIT   = 7;
  localparam int TDR_WRITE_LOCKED_FLAG_BIT = 7;
  localparam int TDR_READ_LOCKED_FLAG_BIT = 6;
  localparam int TDR_ERR_BIT    = 0;

  // Link bit counter
  localparam logic [2:0] TDR_CNT_ZERO = 3'h0;
  localparam logic [2:0] TDR_CNT_ONE  = 3'h1;
  localparam logic [2:0] TDR_CNT_LAST = 3'h7;

  // Link commands, sent LSB first after the start bit
  typedef enum logic [1:0] {
    TDR_CMD_ADDR_WR = 2'b00,
    TDR_CMD_ADDR_RD = 2'b01,
    TDR_CMD_DATA_WR = 2'b10,
    TDR_CMD_DATA_RD = 2'b11
  } tdr_cmd_t;

  // Link-side frame states
  typedef enum logic [2:0] {
    TDR_LK_IDLE  = 3'b000,
    TDR_LK_CMD   = 3'b001,
    TDR_LK_WDATA = 3'b010,
    TDR_LK_WAIT  = 3'b011,
    TDR_LK_RDATA = 3'b100,
    TDR_LK_END   = 3'b101
  } tdr_lk_state_t;

  // Memory operation states
  typedef enum logic [0:0] {
    TDR_EP_IDLE = 1'b0,
    TDR_EP_BUSY = 1'b1
  } tdr_ep_state_t;

endpackage

// *** hdl/tdr_debug_regs.sv ***
// Purpose: Register set behind a two-pin debug and programming port
// Assumes: Adapter clocks debug_clock_pin through each whole frame
// Notes:   Link logic runs on the pin clock; requests cross by toggles
`timescale 1ns/1ps

module tdr_debug_regs
  import tdr_pkg::*;
#(
  parameter int         DATA_W  = TDR_DW,
  parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] REV_ID  = 8'h01  // Arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        debug_clock_pin,
  input  wire logic        debug_data_in,
  output logic             debug_data_out,
  output logic             debug_data_oe_n,
  output logic [7:0]       device_control,
  output logic [7:0]       eprom_program_control,
  output logic [15:0]      eprom_address,
  output logic [7:0]       eprom_wdata,
  output logic             eprom_req,
  output logic             eprom_we,
  input  wire logic [7:0]  eprom_rdata,
  input  wire logic        eprom_done,
  input  wire logic        eprom_fail,
  input  wire logic        write_locked_flag,
  input  wire logic        read_locked_flag,
  input  wire logic [7:0]  check_word_0,
  input  wire logic [7:0]  check_word_1,
  input  wire logic [7:0]  check_word_2,
  input  wire logic [7:0]  check_word_3
);

  // The register map is byte wide throughout
  if (DATA_W != 8) begin : g_width_check
    $error("tdr_debug_regs supports only 8-bit registers");
  end

  // Link domain state.
  // Everything here changes only on debug_clock_pin edges; the adapter may
  // stop that clock between frames, so nothing in this struct may rely on
  // time passing while the link is idle.
  typedef struct packed {
    tdr_lk_state_t state;
    logic [2:0]    cnt;
    tdr_cmd_t      cmd;
    logic [7:0]    wbyte;
    logic [7:0]    rbyte;
    logic          req_tgl;
    logic          ack_s1;
    logic          ack_s2;
    logic          ack_seen;
    logic          dout;
    logic          oe_n;
  } tdr_lk_t;

  // System domain state.
  // The request toggle is synchronised by two flops before it is compared,
  // so a frame that starts near a system edge is never seen half-formed.
  typedef struct packed {
    logic          req_s1;
    logic          req_s2;
    logic          req_seen;
    logic          ack_tgl;
    logic [7:0]    ans_byte;
    logic [7:0]    target;
    logic [7:0]    dev_ctl;
    logic [7:0]    prog_ctl;
    logic [7:0]    ep_data;
    logic [7:0]    addr_hi;
    logic [7:0]    addr_lo;
    logic          err;
    tdr_ep_state_t ep_state;
    logic          ep_req;
    logic          ep_we;
  } tdr_sys_t;

  tdr_lk_t  lk_reg;
  tdr_lk_t  lk_next;
  tdr_sys_t sys_reg;
  tdr_sys_t sys_next;

  // Status byte; unused middle bits read as zero
  function automatic logic [7:0] tdr_status(input logic wl, input logic rl, input logic er);
    logic [7:0] s;
    s = TDR_NO_BYTE;
    s[TDR_WRITE_LOCKED_FLAG_BIT] = wl;
    s[TDR_READ_LOCKED_FLAG_BIT] = rl;
    s[TDR_ERR_BIT]    = er;
    return s;
  endfunction

  // Data read multiplexer keyed by target select
  function automatic logic [7:0] tdr_read_mux(input tdr_sys_t r,
                                              input logic [7:0] st);
    logic [7:0] v;
    v = TDR_NO_BYTE;
    case (r.target)
      TDR_TGT_PART_ID:  v = PART_ID;
      TDR_TGT_REV_ID:   v = REV_ID;
      TDR_TGT_DEV_CTL:  v = r.dev_ctl;
      TDR_TGT_PROG_CTL: v = r.prog_ctl;
      TDR_TGT_EP_DATA:  v = r.ep_data;
      TDR_TGT_EP_STAT:  v = st;
      TDR_TGT_ADDR_HI:  v = r.addr_hi;
      TDR_TGT_ADDR_LO:  v = r.addr_lo;
      TDR_TGT_CHECK_0:  v = check_word_0;
      TDR_TGT_CHECK_1:  v = check_word_1;
      TDR_TGT_CHECK_2:  v = check_word_2;
      TDR_TGT_CHECK_3:  v = check_word_3;
      default:          v = TDR_NO_BYTE;
    endcase
    return v;
  endfunction

  // Link frame: start bit, command, optional write byte, wait, ready, optional read byte.
  // Command and write byte stay frozen until the next frame, so the system
  // side may read them after the request toggle without further crossing.
  always_comb begin
    lk_next        = lk_reg;
    lk_next.ack_s1 = sys_reg.ack_tgl;
    lk_next.ack_s2 = lk_reg.ack_s1;
    case (lk_reg.state)
      TDR_LK_IDLE: begin
        lk_next.oe_n = 1'b1;
        lk_next.dout = 1'b0;
        lk_next.cnt  = TDR_CNT_ZERO;
        if (debug_data_in) begin
          lk_next.state = TDR_LK_CMD;
        end
      end
      TDR_LK_CMD: begin
        lk_next.cmd = tdr_cmd_t'({debug_data_in, lk_reg.cmd[0]});
        if (lk_reg.cnt == TDR_CNT_ZERO) begin
          lk_next.cmd = tdr_cmd_t'({lk_reg.cmd[1], debug_data_in});
          lk_next.cnt = TDR_CNT_ONE;
        end else if (debug_data_in) begin
          // Upper command bit set means a data access
          lk_next.cnt = TDR_CNT_ZERO;
          if (lk_reg.cmd[0]) begin
            lk_next.req_tgl = ~lk_reg.req_tgl;
            lk_next.state   = TDR_LK_WAIT;
            lk_next.oe_n    = 1'b0;
          end else begin
            lk_next.state = TDR_LK_WDATA;
          end
        end else begin
          lk_next.cnt = TDR_CNT_ZERO;
          if (lk_reg.cmd[0]) begin
            lk_next.req_tgl = ~lk_reg.req_tgl;
            lk_next.state   = TDR_LK_WAIT;
            lk_next.oe_n    = 1'b0;
          end else begin
            lk_next.state = TDR_LK_WDATA;
          end
        end
      end
      TDR_LK_WDATA: begin
        lk_next.wbyte[lk_reg.cnt] = debug_data_in;
        lk_next.cnt = lk_reg.cnt + TDR_CNT_ONE;
        if (lk_reg.cnt == TDR_CNT_LAST) begin
          lk_next.cnt     = TDR_CNT_ZERO;
          lk_next.req_tgl = ~lk_reg.req_tgl;
          lk_next.state   = TDR_LK_WAIT;
          lk_next.oe_n    = 1'b0;       // Take the line after the last bit
        end
      end
      TDR_LK_WAIT: begin
        // Drive low until the system side answers, then a one as ready
        lk_next.oe_n = 1'b0;
        lk_next.dout = 1'b0;
        if (lk_reg.ack_s2 != lk_reg.ack_seen) begin
          lk_next.ack_seen = lk_reg.ack_s2;
          lk_next.dout     = 1'b1;
          lk_next.rbyte    = sys_reg.ans_byte; // Stable since the ack toggle
          lk_next.cnt      = TDR_CNT_ZERO;
          if (lk_reg.cmd == TDR_CMD_ADDR_RD || lk_reg.cmd == TDR_CMD_DATA_RD) begin
            lk_next.state = TDR_LK_RDATA;
          end else begin
            lk_next.state = TDR_LK_END;
          end
        end
      end
      TDR_LK_RDATA: begin
        lk_next.dout = lk_reg.rbyte[lk_reg.cnt];
        lk_next.cnt  = lk_reg.cnt + TDR_CNT_ONE;
        if (lk_reg.cnt == TDR_CNT_LAST) begin
          lk_next.cnt   = TDR_CNT_ZERO;
          lk_next.state = TDR_LK_END;
        end
      end
      TDR_LK_END: begin
        lk_next.oe_n  = 1'b1;           // Release the line
        lk_next.dout  = 1'b0;
        lk_next.state = TDR_LK_IDLE;
      end
      default: begin
        lk_next.state = TDR_LK_IDLE;
        lk_next.oe_n  = 1'b1;
      end
    endcase
  end

  // Link registers on the adapter's clock
  always_ff @(posedge debug_clock_pin or posedge rst) begin
    if (rst) begin
      lk_reg <= '{state: TDR_LK_IDLE, cnt: TDR_CNT_ZERO, cmd: TDR_CMD_ADDR_WR,
                  wbyte: TDR_RST_BYTE, rbyte: TDR_RST_BYTE, req_tgl: 1'b0,
                  ack_s1: 1'b0, ack_s2: 1'b0, ack_seen: 1'b0, dout: 1'b0,
                  oe_n: 1'b1};
    end else begin
      lk_reg <= lk_next;
    end
  end

  // System side: one request per toggle, one answer toggle back.
  // A finishing operation and a new request may meet in one cycle; the
  // request still sees busy from the register, so it cannot restart the
  // memory in the same cycle that the old operation ends.
  // Reads of the memory data register return the held byte and start a
  // fresh read, so the adapter reads once more after busy drops.
  always_comb begin
    logic       busy;
    logic [7:0] st;
    busy = 1'b0;
    st   = TDR_NO_BYTE;
    sys_next        = sys_reg;
    sys_next.req_s1 = lk_reg.req_tgl;
    sys_next.req_s2 = sys_reg.req_s1;
    busy = (sys_reg.ep_state == TDR_EP_BUSY);
    st   = tdr_status(write_locked_flag, read_locked_flag, sys_reg.err);

    // Finish an outstanding memory operation
    if (busy && eprom_done) begin
      sys_next.ep_state = TDR_EP_IDLE;
      sys_next.ep_req   = 1'b0;
      sys_next.err      = eprom_fail;
      if (!sys_reg.ep_we && !eprom_fail) begin
        sys_next.ep_data = eprom_rdata;
      end
    end

    if (sys_reg.req_s2 != sys_reg.req_seen) begin
      sys_next.req_seen = sys_reg.req_s2;
      sys_next.ack_tgl  = ~sys_reg.ack_tgl;
      sys_next.ans_byte = TDR_NO_BYTE;
      case (lk_reg.cmd)
        TDR_CMD_ADDR_WR: begin
          sys_next.target = lk_reg.wbyte;
        end
        TDR_CMD_ADDR_RD: begin
          sys_next.ans_byte = TDR_NO_BYTE;
          sys_next.ans_byte[TDR_BUSY_BIT] = busy;
        end
        TDR_CMD_DATA_WR: begin
          // Data writes to any target are dropped while an operation is running
          if (!busy) begin
            case (sys_reg.target)
              TDR_TGT_DEV_CTL:  sys_next.dev_ctl  = lk_reg.wbyte;
              TDR_TGT_PROG_CTL: sys_next.prog_ctl = lk_reg.wbyte;
              TDR_TGT_ADDR_HI:  sys_next.addr_hi  = lk_reg.wbyte;
              TDR_TGT_ADDR_LO:  sys_next.addr_lo  = lk_reg.wbyte;
              TDR_TGT_EP_DATA: begin
                sys_next.ep_data = lk_reg.wbyte;
                if (sys_reg.prog_ctl == TDR_RST_BYTE || write_locked_flag) begin
                  sys_next.err = 1'b1;
                end else begin
                  sys_next.ep_state = TDR_EP_BUSY;
                  sys_next.ep_req   = 1'b1;
                  sys_next.ep_we    = 1'b1;
                  sys_next.err      = 1'b0;
                end
              end
              default: ;
            endcase
          end
        end
        TDR_CMD_DATA_RD: begin
          sys_next.ans_byte = tdr_read_mux(sys_reg, st);
          if (sys_reg.target == TDR_TGT_EP_DATA && !busy) begin
            if (read_locked_flag) begin
              sys_next.err = 1'b1;
            end else begin
              sys_next.ep_state = TDR_EP_BUSY;
              sys_next.ep_req   = 1'b1;
              sys_next.ep_we    = 1'b0;
              sys_next.err      = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // System registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_reg <= '{req_s1: 1'b0, req_s2: 1'b0, req_seen: 1'b0, ack_tgl: 1'b0,
                   ans_byte: TDR_RST_BYTE, target: TDR_RST_BYTE,
                   dev_ctl: TDR_RST_BYTE, prog_ctl: TDR_RST_BYTE,
                   ep_data: TDR_RST_BYTE, addr_hi: TDR_RST_BYTE,
                   addr_lo: TDR_RST_BYTE, err: 1'b0, ep_state: TDR_EP_IDLE,
                   ep_req: 1'b0, ep_we: 1'b0};
    end else begin
      sys_reg <= sys_next;
    end
  end

  // Outputs straight from the registers
  assign debug_data_out        = lk_reg.dout;
  assign debug_data_oe_n       = lk_reg.oe_n;
  assign device_control        = sys_reg.dev_ctl;
  assign eprom_program_control = sys_reg.prog_ctl;
  assign eprom_address         = {sys_reg.addr_hi, sys_reg.addr_lo};
  assign eprom_wdata           = sys_reg.ep_data;
  assign eprom_req             = sys_reg.ep_req;
  assign eprom_we              = sys_reg.ep_we;

endmodule

// *** sim/tdr_props.sv ***
// Purpose: Port checks for the debug register block
// Assumes: Adapter keeps clocking the link through each frame
// Notes:   Two clock domains, each property names its own
`timescale 1ns/1ps
module tdr_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        debug_clock_pin,
  input wire logic        debug_data_out,
  input wire logic        debug_data_oe_n,
  input wire logic [7:0]  device_control,
  input wire logic [7:0]  eprom_program_control,
  input wire logic [15:0] eprom_address,
  input wire logic [7:0]  eprom_wdata,
  input wire logic        eprom_req,
  input wire logic        eprom_we,
  input wire logic        eprom_done,
  input wire logic        write_locked_flag,
  input wire logic        read_locked_flag
);
  // Steps of one memory operation
  sequence s_wr_start;
    $rose(eprom_req) && eprom_we;
  endsequence
  sequence s_rd_start;
    $rose(eprom_req) && !eprom_we;
  endsequence
  sequence s_op_end;
    eprom_req && eprom_done;
  endsequence

  a_write_gated: assert property (@(posedge clk_sys) disable iff (rst)
    s_wr_start |-> eprom_program_control != 8'h00 && !write_locked_flag)
    else $error("write started while barred");
  a_read_gated: assert property (@(posedge clk_sys) disable iff (rst)
    s_rd_start |-> !read_locked_flag) else $error("read started while locked");
  a_req_held: assert property (@(posedge clk_sys) disable iff (rst)
    eprom_req && !eprom_done |=> eprom_req) else $error("request dropped early");
  a_req_drop: assert property (@(posedge clk_sys) disable iff (rst)
    s_op_end |=> !eprom_req) else $error("request outlived done");
  // Address and data must not move under a running operation
  a_op_frozen: assert property (@(posedge clk_sys) disable iff (rst)
    eprom_req && $past(eprom_req) |-> $stable(eprom_address) && $stable(eprom_we)
    && $stable(eprom_wdata)) else $error("operation fields changed");
  a_reset_clear: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> device_control == 8'h00 && eprom_program_control == 8'h00
    && eprom_address == 16'h0000 && !eprom_req) else $error("reset values wrong");
  a_wait_first: assert property (@(posedge debug_clock_pin) disable iff (rst)
    $fell(debug_data_oe_n) |-> !debug_data_out) else $error("answer not opened by wait");
  a_frame_ends: assert property (@(posedge debug_clock_pin) disable iff (rst)
    $fell(debug_data_oe_n) |-> ##[1:80] debug_data_oe_n) else $error("pin never released");
  a_idle_gap: assert property (@(posedge debug_clock_pin) disable iff (rst)
    $rose(debug_data_oe_n) |=> debug_data_oe_n[*3]) else $error("pin driven too soon");
endmodule

bind tdr_debug_regs tdr_props u_props (.clk_sys, .rst, .debug_clock_pin, .debug_data_out,
  .debug_data_oe_n, .device_control, .eprom_program_control, .eprom_address, .eprom_wdata,
  .eprom_req, .eprom_we, .eprom_done, .write_locked_flag, .read_locked_flag);

// *** sim/tdr_adapter.sv ***
// Purpose: Debug adapter model driving the two-pin link
// Assumes: Link clock stands still between frames
// Notes:   Released line shows the inverse of its last level
`timescale 1ns/1ps
module tdr_adapter (
  output logic      debug_clock_pin,
  output logic      debug_data_in,
  input wire logic  debug_data_out,
  input wire logic  debug_data_oe_n
);
  logic drv = 1'b0;
  logic rel = 1'b0;

  // Wire level from both parties; no pull, so a floating line flips
  assign debug_data_in = !debug_data_oe_n ? debug_data_out : (rel ? ~drv : drv);
  initial debug_clock_pin = 1'b0;

  // One 12 ns link cycle; device output is read after the fall
  task automatic tick();
    #6 debug_clock_pin = 1'b1;
    #6 debug_clock_pin = 1'b0;
  endtask

  // Whole frame: start, command LSB first, byte, wait, ready, byte, release
  task automatic frame(input logic [1:0] cmd, input logic [7:0] wb,
                       output logic [7:0] rb, output bit ok);
    int n;
    n = 0;
    rb = 8'h00;
    drv = 1'b1;
    tick();
    drv = cmd[0];
    tick();
    drv = cmd[1];
    tick();
    for (int i = 0; i < 8; i++) if (!cmd[0]) begin
      drv = wb[i];
      tick();
    end
    rel = 1'b1;
    while (!(debug_data_oe_n === 1'b0 && debug_data_out === 1'b1) && n < 40) begin
      tick();
      n++;
    end
    for (int i = 0; i < 8; i++) if (cmd[0]) begin
      tick();
      rb[i] = debug_data_out;
    end
    while (debug_data_oe_n !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    rel = 1'b0;
    drv = 1'b0;
    tick();
    ok = (n < 40);
  endtask
endmodule

// *** sim/tdr_debug_regs_tb_top.sv ***
// Purpose: Self-checking bench for the debug register block
// Assumes: Memory model answers each request after a fixed delay
// Notes:   Every scenario judges its own results before returning
`timescale 1ns/1ps
module tdr_debug_regs_tb_top;
  import tdr_pkg::*;
  localparam logic [7:0] PID = 8'hC3; // Arbitrary value
  localparam logic [7:0] RID = 8'h4E; // Arbitrary value
  localparam logic [7:0] TG [4] = '{TDR_TGT_DEV_CTL, TDR_TGT_PROG_CTL,
                                    TDR_TGT_ADDR_HI, TDR_TGT_ADDR_LO};
  localparam logic [7:0] VAL [4] = '{8'h5C, 8'h01, 8'h9E, 8'h37};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        debug_clock_pin, debug_data_in, debug_data_out, debug_data_oe_n;
  logic [7:0]  device_control, eprom_program_control, eprom_wdata, rb;
  logic [15:0] eprom_address;
  logic        eprom_req, eprom_we, eprom_done = 1'b0, eprom_fail = 1'b0;
  logic        write_locked_flag = 1'b0, read_locked_flag = 1'b0;
  logic [7:0]  eprom_rdata = 8'h00;
  logic [7:0]  cw [4] = '{default: 8'h00};
  bit          ok;
  int          cnt = 0, n_mismatch = 0, comparisons = 0;

  tdr_debug_regs #(.PART_ID(PID), .REV_ID(RID)) dut (.clk_sys, .rst, .debug_clock_pin,
    .debug_data_in, .debug_data_out, .debug_data_oe_n, .device_control,
    .eprom_program_control, .eprom_address, .eprom_wdata, .eprom_req, .eprom_we,
    .eprom_rdata, .eprom_done, .eprom_fail, .write_locked_flag, .read_locked_flag,
    .check_word_0(cw[0]), .check_word_1(cw[1]), .check_word_2(cw[2]), .check_word_3(cw[3]));
  tdr_adapter u_adp (.debug_clock_pin, .debug_data_in, .debug_data_out, .debug_data_oe_n);

  always #10 clk_sys = ~clk_sys;

  // Memory answers 41 cycles after a request, long enough to poll busy
  always @(posedge clk_sys) begin
    eprom_done <= 1'b0;
    if (!eprom_req || eprom_done) cnt <= 0;
    else if (cnt == 40) begin
      eprom_done <= 1'b1;
      eprom_rdata <= 8'hA5;
    end else cnt <= cnt + 1;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic [1:0] c, input logic [7:0] wb);
    u_adp.frame(c, wb, rb, ok);
    check("ready", ok, 1'b1);
  endtask
  task automatic wreg(input logic [7:0] t, input logic [7:0] v);
    xfer(TDR_CMD_ADDR_WR, t);
    xfer(TDR_CMD_DATA_WR, v);
  endtask
  task automatic rreg(input logic [7:0] t);
    xfer(TDR_CMD_ADDR_WR, t);
    xfer(TDR_CMD_DATA_RD, 8'h00);
  endtask
  // Bounded wait for the memory operation to finish
  task automatic wait_idle();
    for (int i = 0; i < 200 && eprom_req !== 1'b0; i++) @(posedge clk_sys);
    check("req end", eprom_req, 1'b0);
  endtask

  task automatic t_ids();
    rreg(TDR_TGT_PART_ID);
    check("part", rb, PID);
    wreg(TDR_TGT_REV_ID, 8'h00);
    rreg(TDR_TGT_REV_ID);
    check("rev", rb, RID);
    rreg(8'h55);
    check("unmapped", rb, 8'h00);
    $display("test ids done");
  endtask
  task automatic t_regs();
    check("ctl rst", device_control, 8'h00);
    check("prog rst", eprom_program_control, 8'h00);
    for (int i = 0; i < 4; i++) wreg(TG[i], VAL[i]);
    for (int i = 0; i < 4; i++) begin
      rreg(TG[i]);
      check("readback", rb, VAL[i]);
    end
    check("ctl", device_control, 8'h5C);
    check("addr", eprom_address, 16'h9E37);
    $display("test regs done");
  endtask
  task automatic t_checks();
    @(posedge clk_sys);
    foreach (cw[i]) cw[i] <= 8'hC0 + 8'(i);
    for (int i = 0; i < 4; i++) begin
      rreg(TDR_TGT_CHECK_0 + 8'(i));
      check("check word", rb, 8'hC0 + 8'(i));
    end
    $display("test checks done");
  endtask
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      write_locked_flag <= i[1];
      read_locked_flag <= i[0];
      wreg(TDR_TGT_EP_STAT, 8'h3F);
      xfer(TDR_CMD_DATA_RD, 8'h00);
      check("status", rb, {i[1], i[0], 6'h00});
    end
    @(posedge clk_sys);
    write_locked_flag <= 1'b0;
    read_locked_flag <= 1'b0;
    $display("test status done");
  endtask
  task automatic t_write();
    wreg(TDR_TGT_PROG_CTL, 8'h00);
    wreg(TDR_TGT_EP_DATA, 8'h3C);
    check("req off", eprom_req, 1'b0);
    rreg(TDR_TGT_EP_STAT);
    check("err", rb, 8'h01);
    wreg(TDR_TGT_PROG_CTL, 8'h01);
    wreg(TDR_TGT_EP_DATA, 8'h3C);
    check("req wr", {eprom_req, eprom_we, eprom_wdata}, {2'b11, 8'h3C});
    xfer(TDR_CMD_ADDR_RD, 8'h00);
    check("busy", rb[7], 1'b1);
    wait_idle();
    xfer(TDR_CMD_ADDR_RD, 8'h00);
    check("idle", rb, 8'h00);
    rreg(TDR_TGT_EP_STAT);
    check("err clr", rb, 8'h00);
    $display("test write done");
  endtask
  task automatic t_read();
    @(posedge clk_sys);
    read_locked_flag <= 1'b1;
    rreg(TDR_TGT_EP_DATA);
    check("rd refused", eprom_req, 1'b0);
    rreg(TDR_TGT_EP_STAT);
    check("rd err", rb, 8'h41);
    @(posedge clk_sys);
    read_locked_flag <= 1'b0;
    eprom_fail <= 1'b1;
    rreg(TDR_TGT_EP_DATA);
    check("held", {rb, eprom_req, eprom_we}, {8'h3C, 2'b10});
    wait_idle();
    rreg(TDR_TGT_EP_STAT);
    check("fail err", rb, 8'h01);
    @(posedge clk_sys);
    eprom_fail <= 1'b0;
    rreg(TDR_TGT_EP_DATA);
    wait_idle();
    xfer(TDR_CMD_DATA_RD, 8'h00);
    check("fresh", rb, 8'hA5);
    wait_idle();
    $display("test read done");
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_ids();
    t_regs();
    t_checks();
    t_status();
    t_write();
    t_read();
    test_done();
  end
  // About 70 frames of under 1 us each; far beyond that means a hang
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule
